// >>> core/ilc_line_ctrl.sv
// Per-line interrupt, open-drain, pull-up, peripheral-select, output latch
// Assumes pins and register port are synchronous to ref_clk
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module ilc_line_ctrl (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    input  wire logic [31:0] pinIn,
    output logic      [31:0] pinOut,
    output logic      [31:0] pinOe,
    output logic      [31:0] pullupOn,
    output logic      [31:0] periphSecond,
    output logic             irq
);
    // Stored per-line state and its next value, one word per concern
    logic [31:0] irqMask_reg;
    logic [31:0] irqMask_next;
    logic [31:0] chgStat_reg;
    logic [31:0] chgStat_next;
    logic [31:0] openDrain_reg;
    logic [31:0] openDrain_next;
    logic [31:0] pullupOff_reg;
    logic [31:0] pullupOff_next;
    logic [31:0] periphB_reg;
    logic [31:0] periphB_next;
    logic [31:0] latchWrEn_reg;
    logic [31:0] latchWrEn_next;
    logic [31:0] outLatch_reg;
    logic [31:0] outLatch_next;
    logic [31:0] pinPrev_reg;
    logic [31:0] rdData_next;
    logic [31:0] readMux;
    logic [31:0] pinChange;

    // Register strobes, decoded once and shared by the state blocks
    logic        wrIrqEn;
    logic        wrIrqDis;
    logic        wrOdEn;
    logic        wrOdDis;
    logic        wrPuDis;
    logic        wrPuEn;
    logic        wrPerA;
    logic        wrPerB;
    logic        wrLwEn;
    logic        wrLwDis;
    logic        wrLatch;
    logic        rdStat;

    // Address match against one register offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // Set/clear of a state word; one address per strobe means
    // set and clear never meet in one cycle
    function automatic logic [31:0] setClr(input logic [31:0] cur,
                                           input logic s, input logic c,
                                           input logic [31:0] d);
        setClr = s ? (cur | d) : (c ? (cur & ~d) : cur);
    endfunction : setClr

    // Write decode; at most one strobe fires, unmapped offsets do nothing
    always_comb
    begin
        wrIrqEn  = 1'b0;
        wrIrqDis = 1'b0;
        wrOdEn   = 1'b0;
        wrOdDis  = 1'b0;
        wrPuDis  = 1'b0;
        wrPuEn   = 1'b0;
        wrPerA   = 1'b0;
        wrPerB   = 1'b0;
        wrLwEn   = 1'b0;
        wrLwDis  = 1'b0;
        wrLatch  = 1'b0;
        if (regWr && hit(regAddr, ilc_pkg::IRQ_ENABLE))
        begin
            wrIrqEn = 1'b1;
        end
        else if (regWr && hit(regAddr, ilc_pkg::IRQ_DISABLE))
        begin
            wrIrqDis = 1'b1;
        end
        else if (regWr && hit(regAddr, ilc_pkg::OD_ENABLE))
        begin
            wrOdEn = 1'b1;
        end
        else if (regWr && hit(regAddr, ilc_pkg::OD_DISABLE))
        begin
            wrOdDis = 1'b1;
        end
        else if (regWr && hit(regAddr, ilc_pkg::PULLUP_DISABLE))
        begin
            wrPuDis = 1'b1;
        end
        else if (regWr && hit(regAddr, ilc_pkg::PULLUP_ENABLE))
        begin
            wrPuEn = 1'b1;
        end
        else if (regWr && hit(regAddr, ilc_pkg::PERIPH_FIRST))
        begin
            wrPerA = 1'b1;
        end
        else if (regWr && hit(regAddr, ilc_pkg::PERIPH_SECOND))
        begin
            wrPerB = 1'b1;
        end
        else if (regWr && hit(regAddr, ilc_pkg::LATCH_WR_ENABLE))
        begin
            wrLwEn = 1'b1;
        end
        else if (regWr && hit(regAddr, ilc_pkg::LATCH_WR_DISABL))
        begin
            wrLwDis = 1'b1;
        end
        else if (regWr && hit(regAddr, ilc_pkg::OUT_DATA_LATCH))
        begin
            wrLatch = 1'b1;
        end
    end

    // Status read strobe, the only read with a side effect
    assign rdStat = regRd && hit(regAddr, ilc_pkg::INPUT_CHG_STAT);

    // Any level difference against the last enabled-cycle sample
    assign pinChange = pinIn ^ pinPrev_reg;

    // Enable sets, disable clears; zero bits leave lines alone
    always_comb
    begin
        irqMask_next = setClr(irqMask_reg, wrIrqEn, wrIrqDis, regWdata);
    end

    // Interrupt enable state
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irqMask_reg <= ilc_pkg::RST_ZERO;
        end
        else if (clkEn)
        begin
            irqMask_reg <= irqMask_next;
        end
    end

    // Read clears; a change in the same cycle wins so none is lost
    always_comb
    begin
        chgStat_next = (rdStat ? 32'h0000_0000 : chgStat_reg) | pinChange;
    end

    // Sticky input-change status
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            chgStat_reg <= ilc_pkg::RST_ZERO;
        end
        else if (clkEn)
        begin
            chgStat_reg <= chgStat_next;
        end
    end

    // Open-drain set and clear
    always_comb
    begin
        openDrain_next = setClr(openDrain_reg, wrOdEn, wrOdDis, regWdata);
    end

    // Open-drain state
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            openDrain_reg <= ilc_pkg::RST_ZERO;
        end
        else if (clkEn)
        begin
            openDrain_reg <= openDrain_next;
        end
    end

    // Pull-up kept as "off" so the inverted status reads it directly
    always_comb
    begin
        pullupOff_next = setClr(pullupOff_reg, wrPuDis, wrPuEn, regWdata);
    end

    // Pull-up state
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pullupOff_reg <= ilc_pkg::RST_PULLUP_ON;
        end
        else if (clkEn)
        begin
            pullupOff_reg <= pullupOff_next;
        end
    end

    // Second select sets, first select clears
    always_comb
    begin
        periphB_next = setClr(periphB_reg, wrPerB, wrPerA, regWdata);
    end

    // Peripheral selection, one means second function
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            periphB_reg <= ilc_pkg::RST_ZERO;
        end
        else if (clkEn)
        begin
            periphB_reg <= periphB_next;
        end
    end

    // Latch write permission set and clear
    always_comb
    begin
        latchWrEn_next = setClr(latchWrEn_reg, wrLwEn, wrLwDis, regWdata);
    end

    // Latch write permission
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            latchWrEn_reg <= ilc_pkg::RST_ZERO;
        end
        else if (clkEn)
        begin
            latchWrEn_reg <= latchWrEn_next;
        end
    end

    // Direct latch write touches permitted lines only
    always_comb
    begin
        if (wrLatch)
        begin
            outLatch_next = (outLatch_reg & ~latchWrEn_reg)
                          | (regWdata & latchWrEn_reg);
        end
        else
        begin
            outLatch_next = outLatch_reg;
        end
    end

    // Output data latch
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            outLatch_reg <= ilc_pkg::RST_ZERO;
        end
        else if (clkEn)
        begin
            outLatch_reg <= outLatch_next;
        end
    end

    // Previous pin level; a line high at reset release shows as a change
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pinPrev_reg <= ilc_pkg::RST_ZERO;
        end
        else if (clkEn)
        begin
            pinPrev_reg <= pinIn;
        end
    end

    // Pad drive: open-drain lines only enable when pulling low
    always_comb
    begin
        pinOut = outLatch_reg;
        pinOe  = ~openDrain_reg | ~outLatch_reg;
    end

    // Pull-up control is the inverse of the stored "off" word
    assign pullupOn     = ~pullupOff_reg;

    // Selection goes straight to the pin multiplexer
    assign periphSecond = periphB_reg;

    // Level request while any enabled line has a pending change
    assign irq          = |(chgStat_reg & irqMask_reg);

    // Read decode; unmapped and write-only offsets read zero
    always_comb
    begin
        if (hit(regAddr, ilc_pkg::IRQ_MASK_STATUS))
        begin
            readMux = irqMask_reg;
        end
        else if (hit(regAddr, ilc_pkg::INPUT_CHG_STAT))
        begin
            readMux = chgStat_reg;
        end
        else if (hit(regAddr, ilc_pkg::OD_STATUS))
        begin
            readMux = openDrain_reg;
        end
        else if (hit(regAddr, ilc_pkg::PULLUP_STATUS))
        begin
            readMux = pullupOff_reg;
        end
        else if (hit(regAddr, ilc_pkg::PERIPH_STATUS))
        begin
            readMux = periphB_reg;
        end
        else if (hit(regAddr, ilc_pkg::LATCH_WR_STATUS))
        begin
            readMux = latchWrEn_reg;
        end
        else if (hit(regAddr, ilc_pkg::OUT_DATA_LATCH))
        begin
            readMux = outLatch_reg;
        end
        else
        begin
            readMux = 32'h0000_0000;
        end
    end

    // Zero after enabled non-read cycles; stale data lingers only while clkEn is low
    always_comb
    begin
        if (regRd)
        begin
            rdData_next = readMux;
        end
        else
        begin
            rdData_next = 32'h0000_0000;
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            regRdata <= ilc_pkg::RST_ZERO;
        end
        else if (clkEn)
        begin
            regRdata <= rdData_next;
        end
    end
endmodule : ilc_line_ctrl

`default_nettype wire

// >>> core/ilc_pkg.sv
// Package for the per-line I/O control block: register offsets, reset values
// Assumes a plain address/strobe register port with 32-bit words
package ilc_pkg;
    localparam int          LINES           = 32;
    localparam int          ADDR_W          = 8;
    // Byte offsets, one aligned word each
    localparam logic [7:0]  IRQ_ENABLE      = 8'h00;
    localparam logic [7:0]  IRQ_DISABLE     = 8'h04;
    localparam logic [7:0]  IRQ_MASK_STATUS = 8'h08;
    localparam logic [7:0]  INPUT_CHG_STAT  = 8'h0C;
    localparam logic [7:0]  OD_ENABLE       = 8'h10;
    localparam logic [7:0]  OD_DISABLE      = 8'h14;
    localparam logic [7:0]  OD_STATUS       = 8'h18;
    localparam logic [7:0]  PULLUP_DISABLE  = 8'h1C;
    localparam logic [7:0]  PULLUP_ENABLE   = 8'h20;
    localparam logic [7:0]  PULLUP_STATUS   = 8'h24;
    localparam logic [7:0]  PERIPH_FIRST    = 8'h28;
    localparam logic [7:0]  PERIPH_SECOND   = 8'h2C;
    localparam logic [7:0]  PERIPH_STATUS   = 8'h30;
    localparam logic [7:0]  LATCH_WR_ENABLE = 8'h34;
    localparam logic [7:0]  LATCH_WR_DISABL = 8'h38;
    localparam logic [7:0]  LATCH_WR_STATUS = 8'h3C;
    localparam logic [7:0]  OUT_DATA_LATCH  = 8'h40;
    // Values after reset
    localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
    localparam logic [31:0] RST_PULLUP_ON   = 32'h0000_0000;
endpackage : ilc_pkg

// >>> sim/ilc_line_ctrl_monitor.sv
// Port-side assertions for the per-line control block
// Assumes one clock and an async high reset
`timescale 1ns/1ps
`default_nettype none
module ilc_line_ctrl_monitor (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        clkEn,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    input wire logic [31:0] pinIn,
    input wire logic [31:0] pinOut,
    input wire logic [31:0] pinOe,
    input wire logic [31:0] pullupOn,
    input wire logic [31:0] periphSecond,
    input wire logic        irq
);
    // Strobes only count on enabled cycles
    wire logic wr = regWr & clkEn;
    wire logic rd = regRd & clkEn;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    rd_idle_a: assert property (clkEn && !rd |=> regRdata == 32'h0)
        else $error("read data not idle");
    pu_status_a: assert property (rd && regAddr == ilc_pkg::PULLUP_STATUS
        |=> regRdata == ~$past(pullupOn)) else $error("pull-up status wrong");
    od_low_a: assert property (rd && regAddr == ilc_pkg::OD_STATUS
        |=> (regRdata & $past(pinOut) & $past(pinOe)) == 32'h0) else $error("drove high");
    ab_status_a: assert property (rd && regAddr == ilc_pkg::PERIPH_STATUS
        |=> regRdata == $past(periphSecond)) else $error("select status wrong");
    latch_read_a: assert property (rd && regAddr == ilc_pkg::OUT_DATA_LATCH
        |=> regRdata == $past(pinOut)) else $error("latch readback wrong");
    sel_first_a: assert property (wr && regAddr == ilc_pkg::PERIPH_FIRST
        |=> (periphSecond & $past(regWdata)) == 32'h0) else $error("first not chosen");
    sel_second_a: assert property (wr && regAddr == ilc_pkg::PERIPH_SECOND
        |=> (periphSecond & $past(regWdata)) == $past(regWdata)) else $error("second lost");
    pu_off_a: assert property (wr && regAddr == ilc_pkg::PULLUP_DISABLE
        |=> (pullupOn & $past(regWdata)) == 32'h0) else $error("pull-up still on");
    irq_off_a: assert property (wr && regAddr == ilc_pkg::IRQ_DISABLE
        && regWdata == 32'hFFFF_FFFF |=> !irq) else $error("irq while masked");
endmodule : ilc_line_ctrl_monitor
bind ilc_line_ctrl ilc_line_ctrl_monitor ilc_line_ctrl_monitor_i (.ref_clk, .sys_rst,
    .clkEn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .pinIn, .pinOut, .pinOe,
    .pullupOn, .periphSecond, .irq);
`default_nettype wire

// >>> sim/ilc_pin_model.sv
// Far side of the pins: an outside driver on every released line
// Assumes pins settle in the cycle the drive changes
`timescale 1ns/1ps
`default_nettype none
module ilc_pin_model (
    input wire logic [31:0] pinOut,
    input wire logic [31:0] pinOe,
    input wire logic [31:0] extVal,
    output logic     [31:0] pinIn
);
    // Block drive wins; a released line shows the outside level
    assign pinIn = (pinOe & pinOut) | (~pinOe & extVal);
endmodule : ilc_pin_model
`default_nettype wire

// >>> sim/io_line_ctrl_irq_drive_mux_test.sv
// Bench: register sequences, pin drive and input-change events
// Assumes the pin model on the far side
`timescale 1ns/1ps
`default_nettype none
module io_line_ctrl_irq_drive_mux_test;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic        clkEn = 1'b1;
    logic [31:0] extVal = 32'h0;
    logic [31:0] regRdata, pinIn, pinOut, pinOe, pullupOn, periphSecond;
    logic        irq;
    int          badCount = 0;
    int          cmpCount = 0;
    // Set, clear and status offsets of each pair
    logic [7:0]  pairs [5][3] = '{'{8'h00, 8'h04, 8'h08}, '{8'h10, 8'h14, 8'h18},
        '{8'h1C, 8'h20, 8'h24}, '{8'h2C, 8'h28, 8'h30}, '{8'h34, 8'h38, 8'h3C}};
    ilc_line_ctrl ilc_line_ctrl_i (.ref_clk, .sys_rst, .clkEn, .regAddr, .regWdata,
        .regWr, .regRd, .regRdata, .pinIn, .pinOut, .pinOe, .pullupOn, .periphSecond, .irq);
    ilc_pin_model ilc_pin_model_i (.pinOut, .pinOe, .extVal, .pinIn);
    always #5 ref_clk = ~ref_clk;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmpCount++;
        if (s !== e)
        begin
            badCount++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask : chk
    // Called on a rising edge; one idle cycle after each strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    // Read data stand only in the cycle after the taking edge
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        chk("regRdata", regRdata, e);
        @(posedge ref_clk);
    endtask : rd
    task automatic results;
        $display("Compares %0d, mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    // Main sequence
    initial
    begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rd(8'h44, 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            rd(pairs[i][2], 32'h0);
            wr(pairs[i][0], 32'hA5A5_A5A5);
            wr(pairs[i][1], 32'h0000_FFFF);
            wr(pairs[i][0], 32'h0);
            rd(pairs[i][2], 32'hA5A5_0000);
        end
        wr(ilc_pkg::OUT_DATA_LATCH, 32'hFFFF_FFFF);
        rd(ilc_pkg::OUT_DATA_LATCH, 32'hA5A5_0000);
        chk("pinOut", pinOut, 32'hA5A5_0000);
        chk("pinOe", pinOe, 32'h5A5A_FFFF);
        chk("pullupOn", pullupOn, 32'h5A5A_FFFF);
        chk("periphSecond", periphSecond, 32'hA5A5_0000);
        rd(ilc_pkg::INPUT_CHG_STAT, 32'h0);
        // Released lines rise; status and request follow one edge later
        extVal <= 32'hFFFF_FFFF;
        repeat (3) @(posedge ref_clk);
        chk("irq", {31'h0, irq}, 32'h1);
        rd(ilc_pkg::INPUT_CHG_STAT, 32'hA5A5_0000);
        rd(ilc_pkg::INPUT_CHG_STAT, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        extVal <= 32'h0;
        wr(ilc_pkg::IRQ_DISABLE, 32'hFFFF_FFFF);
        repeat (2) @(posedge ref_clk);
        chk("irq", {31'h0, irq}, 32'h0);
        rd(ilc_pkg::INPUT_CHG_STAT, 32'hA5A5_0000);
        // A write while the clock enable is low must leave no trace
        clkEn <= 1'b0;
        wr(ilc_pkg::IRQ_ENABLE, 32'hFFFF_FFFF);
        clkEn <= 1'b1;
        rd(ilc_pkg::IRQ_MASK_STATUS, 32'h0);
        wr(ilc_pkg::LATCH_WR_DISABL, 32'hFFFF_FFFF);
        wr(ilc_pkg::OUT_DATA_LATCH, 32'h0);
        rd(ilc_pkg::OUT_DATA_LATCH, 32'hA5A5_0000);
        rd(ilc_pkg::LATCH_WR_STATUS, 32'h0);
        results();
    end
    // Run needs under a hundred cycles; a hang is cut well past that, at 2000
    initial
    begin
        #20000;
        badCount++;
        results();
    end
endmodule : io_line_ctrl_irq_drive_mux_test
`default_nettype wire
